// ### pkg/uesc_pkg.sv
// shared constants and types for the endpoint status/control block
package uesc_pkg;
   // register byte offsets on the apb bus
   localparam logic [11:0] UESC_OFF_BSR  = 12'h000;
   localparam logic [11:0] UESC_OFF_EP0  = 12'h004;
   localparam logic [11:0] UESC_OFF_EP1  = 12'h008;
   localparam logic [11:0] UESC_OFF_CTRL = 12'h00c;

   // endpoint direction status codes
   localparam logic [1:0] UESC_ST_DIS   = 2'h0;
   localparam logic [1:0] UESC_ST_STALL = 2'h1;
   localparam logic [1:0] UESC_ST_NAK   = 2'h2;
   localparam logic [1:0] UESC_ST_VALID = 2'h3;

   // upper token pid bits
   localparam logic [1:0] UESC_TOK_OUT   = 2'h0;
   localparam logic [1:0] UESC_TOK_IN    = 2'h2;
   localparam logic [1:0] UESC_TOK_SETUP = 2'h3;

   // endpoint numbers
   localparam logic [1:0] UESC_EP0 = 2'h0;
   localparam logic [1:0] UESC_EP1 = 2'h1;
   localparam logic [1:0] UESC_EP2 = 2'h2;

   // error codes
   localparam logic [2:0] UESC_ERR_NONE  = 3'h0;
   localparam logic [2:0] UESC_ERR_RSVD  = 3'h6;
   localparam logic [2:0] UESC_ERR_OTHER = 3'h7;

   // handshake answer to a token
   typedef enum logic [1:0] {
      UESC_HS_NONE,
      UESC_HS_STALL,
      UESC_HS_NAK,
      UESC_HS_ACK
   } uesc_hs_t;

   // bus status layout, msb first
   typedef struct packed {
      logic [1:0] tok;
      logic       dir;
      logic [1:0] epn;
      logic [2:0] err;
   } uesc_bsr_t;

   // control endpoint layout, msb first
   typedef struct packed {
      logic       done;
      logic       txtog;
      logic [1:0] txst;
      logic       rsvd;
      logic       rxtog;
      logic [1:0] rxst;
   } uesc_ep0_t;

   // endpoint 1 receive layout, msb first
   typedef struct packed {
      logic [3:0] rsvd;
      logic       done;
      logic       rxtog;
      logic [1:0] rxst;
   } uesc_ep1_t;

   localparam uesc_bsr_t UESC_BSR_RST = '0;
   localparam uesc_ep0_t UESC_EP0_RST = '0;
   localparam uesc_ep1_t UESC_EP1_RST = '0;
   localparam logic      UESC_FORCE_INTERFACE_RESET_RST = 1'b0;
endpackage

// ### pkg/uesc_reg_if.sv
// register access carrier between the apb slave and the core
`timescale 1ns/1ps
interface uesc_reg_if;
   logic       wr;
   logic [1:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport slave (output wr, output idx, output wdata, input rdata);
   modport core  (input wr, input idx, input wdata, output rdata);
endinterface

// ### logic/uesc_apb_slave.sv
// apb slave front end: decode, write strobe, registered read data
`timescale 1ns/1ps
module uesc_apb_slave
   import uesc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   uesc_reg_if.slave        rif
);
   typedef struct packed {
      logic [31:0] rdata;
      logic        err;
   } uesc_apb_st_t;

   uesc_apb_st_t st_r;
   uesc_apb_st_t st_nxt;
   logic         mapped;
   logic         setup;

   // only aligned words in the low sixteen bytes exist
   assign mapped = (paddr_i[11:4] == UESC_OFF_BSR[11:4]) &&
                   (paddr_i[1:0] == UESC_OFF_BSR[1:0]);
   assign setup  = psel_i & ~penable_i;
   assign rif.idx   = paddr_i[3:2];
   assign rif.wdata = pwdata_i[7:0];
   // zero wait: write lands at the one access edge; byte lane 0 only
   assign rif.wr = psel_i & penable_i & pwrite_i & mapped & pstrb_i[0];
   assign pready_o  = psel_i & penable_i;
   assign prdata_o  = st_r.rdata;
   assign pslverr_o = st_r.err & psel_i & penable_i;

   // read data captured in setup so it comes from a flop in access
   always_comb begin
      st_nxt = st_r;
      if (setup) begin
         st_nxt.rdata = (mapped && !pwrite_i) ? {24'h0, rif.rdata}
                                              : 32'h0;
         st_nxt.err   = ~mapped;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // uesc_apb_slave

// ### logic/uesc_endpoint_status.sv
// endpoint status/control core with bus status and apb access
// Operation
// RULE1 - record upper two pid bits of ep0 token
// RULE2 - transfer on ep1/ep2 sets direction bit
// RULE3 - report endpoint number needing attention
// RULE4 - three-bit error type code table
// RULE5 - load error code, clear with error flag
// RULE6 - bus status read-only, resets to zero
// RULE7 - bus or forced reset clears ep0 fields
// RULE8 - ep0 done flag set per correct transfer
// RULE9 - setup pid sets transmit toggle to one
// RULE10 - host ack inverts transmit toggle
// RULE11 - software may write both toggle bits
// RULE12 - status field selects ignore/stall/nak/handle
// RULE13 - ep0 correct transfer forces both NAK
// RULE14 - setup stage clears receive toggle
// RULE15 - receive toggle inverts on matching data pid
// RULE16 - enabled ep0 acknowledges setup, both NAK
// RULE17 - stall answer sets both fields STALL
// RULE18 - ep1 high bits zero, low reset clears
// RULE19 - ep1 reception done flag set per transfer
// RULE20 - ep1 status codes, NAK after transfer
// RULE21 - ep0 bit three always reads zero
// RULE22 - global done is OR of endpoint flags
// RULE23 - error code 110 never reported
`timescale 1ns/1ps
module uesc_endpoint_status
   import uesc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   // apb register port
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // events from the usb protocol engine, same clock
   input  wire logic        usb_reset_i,
   input  wire logic        tok_i,
   input  wire logic [1:0]  tok_ep_i,
   input  wire logic [3:0]  tok_pid_i,
   output uesc_hs_t         hs_o,
   input  wire logic        xfer_ok_i,
   input  wire logic [1:0]  xfer_ep_i,
   input  wire logic        xfer_in_i,
   input  wire logic        data_ok_i,
   input  wire logic [1:0]  data_ep_i,
   input  wire logic        data_pid1_i,
   input  wire logic        ep0_ack_i,
   input  wire logic        err_i,
   input  wire logic [2:0]  err_code_i,
   input  wire logic        err_clr_i,
   input  wire logic        other_done_i,
   // state seen by the engine
   output logic             ep0_tx_toggle_o,
   output logic             ep0_rx_toggle_o,
   output logic             ep1_rx_toggle_o,
   output logic             any_transfer_done_o,
   output logic             iface_reset_o
);
   typedef struct packed {
      uesc_bsr_t bsr;
      uesc_ep0_t ep0;
      uesc_ep1_t ep1;
      logic      force_interface_reset;
   } uesc_state_t;

   uesc_state_t st_r;
   uesc_state_t st_nxt;
   uesc_hs_t    hs;
   logic        hw_rst;
   logic        tok_setup;
   logic [1:0]  tok_stat;

   uesc_reg_if rif ();

   uesc_apb_slave u_apb (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .psel_i    (psel_i),
      .penable_i (penable_i),
      .pwrite_i  (pwrite_i),
      .paddr_i   (paddr_i),
      .pwdata_i  (pwdata_i),
      .pstrb_i   (pstrb_i),
      .prdata_o  (prdata_o),
      .pready_o  (pready_o),
      .pslverr_o (pslverr_o),
      .rif       (rif)
   );

   // interface held in reset while the bus resets or software forces it
   assign hw_rst    = usb_reset_i | st_r.force_interface_reset;
   assign tok_setup = (tok_pid_i[3:2] == UESC_TOK_SETUP);

   // read mux: reserved bits are constant zero in the layouts
   always_comb begin
      case (rif.idx)
         UESC_OFF_BSR[3:2]:  rif.rdata = st_r.bsr;
         UESC_OFF_EP0[3:2]:  rif.rdata = st_r.ep0;
         UESC_OFF_EP1[3:2]:  rif.rdata = st_r.ep1;
         UESC_OFF_CTRL[3:2]: rif.rdata = {7'h0, st_r.force_interface_reset};
         default:            rif.rdata = 8'h00;
      endcase
   end

   // status field that governs the current token
   always_comb begin
      if (tok_ep_i == UESC_EP1) begin
         tok_stat = (tok_pid_i[3:2] == UESC_TOK_OUT) ? st_r.ep1.rxst
                                                     : UESC_ST_DIS;
      end else if (tok_pid_i[3:2] == UESC_TOK_IN) begin
         tok_stat = st_r.ep0.txst;
      end else begin
         tok_stat = st_r.ep0.rxst;
      end
   end

   // handshake decision; tokens for other endpoints belong elsewhere
   always_comb begin
      hs = UESC_HS_NONE;
      if (!hw_rst && (tok_ep_i == UESC_EP0 || tok_ep_i == UESC_EP1)) begin
         if (tok_ep_i == UESC_EP0 && tok_setup) begin
            if (st_r.ep0.txst != UESC_ST_DIS ||
                st_r.ep0.rxst != UESC_ST_DIS) begin
               hs = UESC_HS_ACK; // RULE16
            end
         end else begin
            case (tok_stat) // RULE12 RULE20
               UESC_ST_STALL: hs = UESC_HS_STALL;
               UESC_ST_NAK:   hs = UESC_HS_NAK;
               UESC_ST_VALID: hs = UESC_HS_ACK;
               default:       hs = UESC_HS_NONE;
            endcase
         end
      end
   end
   assign hs_o = hs;

   // next state: software first, hardware events after so they win
   always_comb begin
      st_nxt = st_r;
      // software access; bus status has no write path
      if (rif.wr) begin
         case (rif.idx)
            UESC_OFF_EP0[3:2]: begin
               if (!rif.wdata[7]) begin
                  st_nxt.ep0.done = 1'b0; // write zero clears
               end
               st_nxt.ep0.txtog = rif.wdata[6]; // RULE11
               st_nxt.ep0.txst  = rif.wdata[5:4];
               st_nxt.ep0.rxtog = rif.wdata[2]; // RULE11
               st_nxt.ep0.rxst  = rif.wdata[1:0];
            end
            UESC_OFF_EP1[3:2]: begin
               if (!rif.wdata[3]) begin
                  st_nxt.ep1.done = 1'b0;
               end
               st_nxt.ep1.rxtog = rif.wdata[2]; // RULE11
               st_nxt.ep1.rxst  = rif.wdata[1:0];
            end
            UESC_OFF_CTRL[3:2]: begin
               st_nxt.force_interface_reset = rif.wdata[0];
            end
            default: begin
            end
         endcase
      end
      // correct transfer
      if (xfer_ok_i) begin
         st_nxt.bsr.epn = xfer_ep_i; // RULE3
         if (xfer_ep_i != UESC_EP0) begin
            st_nxt.bsr.dir = xfer_in_i; // RULE2
         end
         if (xfer_ep_i == UESC_EP0) begin
            st_nxt.ep0.done = 1'b1; // RULE8
            st_nxt.ep0.txst = UESC_ST_NAK; // RULE13
            st_nxt.ep0.rxst = UESC_ST_NAK; // RULE13
         end
         if (xfer_ep_i == UESC_EP1 && !xfer_in_i) begin
            st_nxt.ep1.done = 1'b1; // RULE19
            st_nxt.ep1.rxst = UESC_ST_NAK; // RULE20
         end
      end
      // token arrival; a setup always restarts the control sequence
      if (tok_i && tok_ep_i == UESC_EP0) begin
         st_nxt.bsr.tok = tok_pid_i[3:2]; // RULE1
         if (hs == UESC_HS_STALL) begin
            st_nxt.ep0.txst = UESC_ST_STALL; // RULE17
            st_nxt.ep0.rxst = UESC_ST_STALL; // RULE17
         end
         if (tok_setup) begin
            st_nxt.ep0.txtog = 1'b1; // RULE9
            st_nxt.ep0.rxtog = 1'b0; // RULE14
         end
         if (tok_setup && hs == UESC_HS_ACK) begin
            st_nxt.ep0.txst = UESC_ST_NAK; // RULE16
            st_nxt.ep0.rxst = UESC_ST_NAK; // RULE16
         end
      end
      if (tok_i && tok_ep_i == UESC_EP1 && hs == UESC_HS_STALL) begin
         st_nxt.ep1.rxst = UESC_ST_STALL; // RULE17
      end
      // good data packet: advance only on the expected pid
      if (data_ok_i && data_ep_i == UESC_EP0 &&
          data_pid1_i == st_r.ep0.rxtog) begin
         st_nxt.ep0.rxtog = ~st_r.ep0.rxtog; // RULE15
      end
      if (data_ok_i && data_ep_i == UESC_EP1 &&
          data_pid1_i == st_r.ep1.rxtog) begin
         st_nxt.ep1.rxtog = ~st_r.ep1.rxtog; // RULE15
      end
      if (ep0_ack_i) begin
         st_nxt.ep0.txtog = ~st_r.ep0.txtog; // RULE10
      end
      // error code: clear with the flag, a new error wins
      if (err_clr_i) begin
         st_nxt.bsr.err = UESC_ERR_NONE; // RULE5
      end
      if (err_i) begin
         // reserved code folds into the catch-all
         st_nxt.bsr.err = (err_code_i == UESC_ERR_RSVD) ? UESC_ERR_OTHER
                                                        : err_code_i; // RULE4 RULE23
      end
      // interface reset keeps the done flags for software
      if (hw_rst) begin
         st_nxt.ep0.txtog = 1'b0; // RULE7
         st_nxt.ep0.txst  = UESC_ST_DIS; // RULE7
         st_nxt.ep0.rxtog = 1'b0; // RULE7
         st_nxt.ep0.rxst  = UESC_ST_DIS; // RULE7
         st_nxt.ep1.rxtog = 1'b0; // RULE18
         st_nxt.ep1.rxst  = UESC_ST_DIS; // RULE18
      end
      // reserved bits never take a value
      st_nxt.ep0.rsvd = 1'b0; // RULE21
      st_nxt.ep1.rsvd = 4'h0; // RULE18
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r.bsr  <= UESC_BSR_RST; // RULE6
         st_r.ep0  <= UESC_EP0_RST;
         st_r.ep1  <= UESC_EP1_RST;
         st_r.force_interface_reset <= UESC_FORCE_INTERFACE_RESET_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign ep0_tx_toggle_o = st_r.ep0.txtog;
   assign ep0_rx_toggle_o = st_r.ep0.rxtog;
   assign ep1_rx_toggle_o = st_r.ep1.rxtog;
   assign iface_reset_o   = st_r.force_interface_reset;
   // cannot be cleared on its own, only through the source flags
   assign any_transfer_done_o = st_r.ep0.done | st_r.ep1.done |
                                other_done_i; // RULE22

   // checks on the recorded state
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   logic quiet0;
   assign quiet0 = !hw_rst && !xfer_ok_i && !tok_i && !data_ok_i &&
                   !ep0_ack_i;

   a_token_record: assert property ( // RULE1
      tok_i && tok_ep_i == UESC_EP0
      |=> st_r.bsr.tok == $past(tok_pid_i[3:2]))
      else $error("ep0 token bits not recorded");

   a_dir_update: assert property ( // RULE2
      xfer_ok_i && xfer_ep_i != UESC_EP0
      |=> st_r.bsr.dir == $past(xfer_in_i))
      else $error("direction bit not updated");

   a_epn_report: assert property ( // RULE3
      xfer_ok_i |=> st_r.bsr.epn == $past(xfer_ep_i))
      else $error("endpoint number not reported");

   a_err_load: assert property ( // RULE4
      err_i && err_code_i != UESC_ERR_RSVD
      |=> st_r.bsr.err == $past(err_code_i))
      else $error("error code not loaded");

   a_err_fold: assert property ( // RULE23
      st_r.bsr.err != UESC_ERR_RSVD)
      else $error("reserved error code reported");

   a_err_clear: assert property ( // RULE5
      err_clr_i && !err_i |=> st_r.bsr.err == UESC_ERR_NONE)
      else $error("error code not cleared");

   a_bsr_ro: assert property ( // RULE6
      rif.wr && !xfer_ok_i && !tok_i && !err_i && !err_clr_i
      |=> $stable(st_r.bsr))
      else $error("bus status changed by a write");

   a_bus_reset: assert property ( // RULE7
      hw_rst |=> st_r.ep0[6:4] == 3'h0 && st_r.ep0[2:0] == 3'h0 &&
                 st_r.ep1[2:0] == 3'h0)
      else $error("reset did not clear endpoint fields");

   a_done_set: assert property ( // RULE8
      xfer_ok_i && xfer_ep_i == UESC_EP0
      |=> st_r.ep0.done ##1 (st_r.ep0.done || $past(rif.wr)))
      else $error("ep0 done flag not set or lost");

   a_setup_seq: assert property ( // RULE9
      tok_i && tok_ep_i == UESC_EP0 && tok_setup && hs == UESC_HS_ACK
      && !hw_rst && !ep0_ack_i && !data_ok_i
      |=> st_r.ep0.txtog && !st_r.ep0.rxtog &&
          st_r.ep0.txst == UESC_ST_NAK && st_r.ep0.rxst == UESC_ST_NAK)
      else $error("setup did not prime toggles and NAK");

   a_ack_toggle: assert property ( // RULE10
      ep0_ack_i && !hw_rst && !tok_i |=> st_r.ep0.txtog != $past(
         st_r.ep0.txtog) || $past(rif.wr))
      else $error("ack did not invert transmit toggle");

   a_sw_toggle: assert property ( // RULE11
      rif.wr && rif.idx == UESC_OFF_EP0[3:2] && quiet0
      |=> st_r.ep0.txtog == $past(rif.wdata[6]) &&
          st_r.ep0.rxtog == $past(rif.wdata[2]))
      else $error("software toggle write lost");

   a_rx_match: assert property ( // RULE15
      data_ok_i && data_ep_i == UESC_EP1 && !hw_rst && !rif.wr
      |=> st_r.ep1.rxtog == ($past(st_r.ep1.rxtog) ^
                             ($past(data_pid1_i) == $past(st_r.ep1.rxtog))))
      else $error("receive toggle rule broken");

   a_stall_both: assert property ( // RULE17
      tok_i && tok_ep_i == UESC_EP0 && hs == UESC_HS_STALL
      |=> st_r.ep0.txst == UESC_ST_STALL &&
          st_r.ep0.rxst == UESC_ST_STALL)
      else $error("stall did not set both fields");

   a_rsvd_zero: assert property ( // RULE21
      st_r.ep0.rsvd == 1'b0 && st_r.ep1.rsvd == 4'h0)
      else $error("reserved bits not zero");

   a_any_done: assert property ( // RULE22
      st_r.ep0.done && !rif.wr |=> any_transfer_done_o)
      else $error("global done flag missing");

   c_setup: cover property (
      tok_i && tok_setup && hs == UESC_HS_ACK ##[1:20] xfer_ok_i);
   c_stall: cover property (tok_i && hs == UESC_HS_STALL);
   c_error: cover property (err_i ##[1:50] err_clr_i);
   c_ep1_rx: cover property (xfer_ok_i && xfer_ep_i == UESC_EP1);
endmodule // uesc_endpoint_status

// ### dv/uesc_host_model.sv
// usb-side traffic model: token, data, handshake and error events
`timescale 1ns/1ps
module uesc_host_model
   import uesc_pkg::*;
(
   input  wire logic       mclk_i,
   input  uesc_hs_t        hs_i,
   output logic            usb_reset_o,
   output logic            tok_o,
   output logic      [1:0] tok_ep_o,
   output logic      [3:0] tok_pid_o,
   output logic            xfer_ok_o,
   output logic      [1:0] xfer_ep_o,
   output logic            xfer_in_o,
   output logic            data_ok_o,
   output logic      [1:0] data_ep_o,
   output logic            data_pid1_o,
   output logic            ack_o,
   output logic            err_o,
   output logic      [2:0] err_code_o,
   output logic            err_clr_o,
   output logic            other_done_o
);
   // strobes low at time zero, qualifiers carry no meaning yet
   initial begin
      {usb_reset_o, tok_o, xfer_ok_o, data_ok_o, ack_o} = '0;
      {err_o, err_clr_o, other_done_o} = '0;
      {tok_ep_o, tok_pid_o, xfer_ep_o, xfer_in_o} = '1;
      {data_ep_o, data_pid1_o, err_code_o} = '1;
   end

   // answer is sampled at the edge that takes the token
   task automatic token(input logic [1:0] ep, input logic [3:0] pid,
                        output uesc_hs_t hs);
      @(posedge mclk_i);
      tok_o     <= 1'b1;
      tok_ep_o  <= ep;
      tok_pid_o <= pid;
      @(posedge mclk_i);
      hs = hs_i;
      tok_o     <= 1'b0;
      // qualifiers are not held past the strobe, so they change here
      tok_ep_o  <= ~ep;
      tok_pid_o <= ~pid;
   endtask

   // correct transfer report
   task automatic xfer(input logic [1:0] ep, input logic in);
      @(posedge mclk_i);
      xfer_ok_o <= 1'b1;
      xfer_ep_o <= ep;
      xfer_in_o <= in;
      @(posedge mclk_i);
      xfer_ok_o <= 1'b0;
      xfer_ep_o <= ~ep;
      xfer_in_o <= ~in;
   endtask

   // good data packet carrying a data0 or data1 pid
   task automatic data(input logic [1:0] ep, input logic p1);
      @(posedge mclk_i);
      data_ok_o   <= 1'b1;
      data_ep_o   <= ep;
      data_pid1_o <= p1;
      @(posedge mclk_i);
      data_ok_o   <= 1'b0;
      data_ep_o   <= ~ep;
      data_pid1_o <= ~p1;
   endtask

   // error event with its type code
   task automatic error(input logic [2:0] c);
      @(posedge mclk_i);
      err_o      <= 1'b1;
      err_code_o <= c;
      @(posedge mclk_i);
      err_o      <= 1'b0;
      err_code_o <= ~c;
   endtask

   // single-cycle pulses
   task automatic ack();
      @(posedge mclk_i);
      ack_o <= 1'b1;
      @(posedge mclk_i);
      ack_o <= 1'b0;
   endtask

   task automatic error_clear();
      @(posedge mclk_i);
      err_clr_o <= 1'b1;
      @(posedge mclk_i);
      err_clr_o <= 1'b0;
   endtask

   // bus reset held for n cycles
   task automatic bus_reset(input int n);
      @(posedge mclk_i);
      usb_reset_o <= 1'b1;
      repeat (n) @(posedge mclk_i);
      usb_reset_o <= 1'b0;
   endtask

   task automatic other(input logic v);
      @(posedge mclk_i);
      other_done_o <= v;
   endtask
endmodule // uesc_host_model

// ### dv/tb.sv
// self-checking bench for the endpoint status and control block
`timescale 1ns/1ps
module tb;
   import uesc_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0]  pstrb = '0;
   logic [31:0] prdata;
   logic        pready, pslverr, ures, tok, xok, xin, dok, dp1, ack;
   logic        err, eclr, odone, txt, rxt, rx1t, anyd, ifr;
   logic [1:0]  tep, xep, dep;
   logic [3:0]  tpid;
   logic [2:0]  ecode;
   uesc_hs_t    hs_w, hs_s;
   logic [32:0] exp_e;
   logic [7:0]  v;
   logic [32:0] exp_q[$];
   int          n_errors = 0;
   int          checked = 0;
   int          cycles = 0;

   uesc_endpoint_status u_dut (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .usb_reset_i(ures),
      .tok_i(tok), .tok_ep_i(tep), .tok_pid_i(tpid), .hs_o(hs_w),
      .xfer_ok_i(xok), .xfer_ep_i(xep), .xfer_in_i(xin),
      .data_ok_i(dok), .data_ep_i(dep), .data_pid1_i(dp1),
      .ep0_ack_i(ack), .err_i(err), .err_code_i(ecode),
      .err_clr_i(eclr), .other_done_i(odone), .ep0_tx_toggle_o(txt),
      .ep0_rx_toggle_o(rxt), .ep1_rx_toggle_o(rx1t),
      .any_transfer_done_o(anyd), .iface_reset_o(ifr));

   uesc_host_model u_host (
      .mclk_i(mclk_i), .hs_i(hs_w), .usb_reset_o(ures), .tok_o(tok),
      .tok_ep_o(tep), .tok_pid_o(tpid), .xfer_ok_o(xok),
      .xfer_ep_o(xep), .xfer_in_o(xin), .data_ok_o(dok),
      .data_ep_o(dep), .data_pid1_o(dp1), .ack_o(ack), .err_o(err),
      .err_code_o(ecode), .err_clr_o(eclr), .other_done_o(odone));

   initial begin
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bchk(input string nm, input logic seen, exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask

   // one apb transfer; the request stands until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [3:0] s);
      @(posedge mclk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      pstrb   <= s;
      @(posedge mclk_i);
      penable <= 1'b1;
      do begin
         @(posedge mclk_i);
      end while (pready !== 1'b1);
      bchk("pready", pready, 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s = 4'hf);
      apb(1'b1, a, d, s);
   endtask

   // a read notes its expectation before the bus cycle starts
   task automatic rd(input logic [11:0] a, input logic [7:0] e,
                     input logic r = 1'b0);
      exp_q.push_back({r, 24'h0, e});
      apb(1'b0, a, 8'h00, 4'h0);
   endtask

   // read monitor: each finished read takes the oldest note
   always @(posedge mclk_i) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) bchk("read_noted", 1'b0, 1'b1);
         else begin
            exp_e = exp_q.pop_front();
            chk("prdata", prdata, exp_e[31:0]);
            bchk("pslverr", pslverr, exp_e[32]);
         end
      end
   end

   // watchdog: the sequence needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      void'($urandom(32'he75f));
      repeat (16) @(posedge mclk_i);
      rstn_i <= 1'b1;
      // reset values, unmapped and misaligned places
      rd(UESC_OFF_BSR, 8'h00);
      rd(UESC_OFF_EP0, 8'h00);
      rd(UESC_OFF_EP1, 8'h00);
      rd(UESC_OFF_CTRL, 8'h00);
      rd(12'h010, 8'h00, 1'b1);
      rd(12'h006, 8'h00, 1'b1);
      // read-only status, reserved bits, missing byte strobe
      wr(UESC_OFF_BSR, 8'hff);
      rd(UESC_OFF_BSR, 8'h00);
      wr(UESC_OFF_EP0, 8'hff);
      rd(UESC_OFF_EP0, 8'h77);
      wr(UESC_OFF_EP1, 8'hff);
      rd(UESC_OFF_EP1, 8'h07);
      wr(UESC_OFF_EP0, 8'h00, 4'he);
      rd(UESC_OFF_EP0, 8'h77);
      // every status code answers both token directions
      for (int st = 0; st < 4; st++) begin
         wr(UESC_OFF_EP0, {2'h0, 2'(st), 2'h0, 2'(st)});
         u_host.token(UESC_EP0, 4'h1, hs_s);
         chk("hs_out", 32'(hs_s), 32'(st));
         u_host.token(UESC_EP0, 4'h9, hs_s);
         chk("hs_in", 32'(hs_s), 32'(st));
      end
      // a stall on transmit drags receive to stall as well
      wr(UESC_OFF_EP0, 8'h13);
      u_host.token(UESC_EP0, 4'h9, hs_s);
      chk("hs_stall", 32'(hs_s), 32'(UESC_HS_STALL));
      rd(UESC_OFF_EP0, 8'h11);
      // setup on a stalled endpoint is still taken
      u_host.token(UESC_EP0, 4'hd, hs_s);
      chk("hs_setup", 32'(hs_s), 32'(UESC_HS_ACK));
      rd(UESC_OFF_EP0, 8'h62);
      rd(UESC_OFF_BSR, 8'hc0);
      bchk("tx_tog", txt, 1'b1);
      // correct transfer: done flag, both nak, global or
      u_host.xfer(UESC_EP0, 1'b0);
      rd(UESC_OFF_EP0, 8'he2);
      bchk("any_done", anyd, 1'b1);
      wr(UESC_OFF_EP0, 8'h62);
      rd(UESC_OFF_EP0, 8'h62);
      bchk("any_done", anyd, 1'b0);
      u_host.other(1'b1);
      @(posedge mclk_i);
      bchk("any_done", anyd, 1'b1);
      u_host.other(1'b0);
      u_host.ack();
      rd(UESC_OFF_EP0, 8'h22);
      // receive toggle moves only on a matching data pid
      wr(UESC_OFF_EP0, 8'h33);
      u_host.data(UESC_EP0, 1'b1);
      rd(UESC_OFF_EP0, 8'h33);
      u_host.data(UESC_EP0, 1'b0);
      rd(UESC_OFF_EP0, 8'h37);
      bchk("rx_tog", rxt, 1'b1);
      // endpoint 1 reception and direction reporting
      wr(UESC_OFF_EP1, 8'h02);
      u_host.token(UESC_EP1, 4'h1, hs_s);
      chk("hs_ep1", 32'(hs_s), 32'(UESC_HS_NAK));
      wr(UESC_OFF_EP1, 8'h03);
      u_host.data(UESC_EP1, 1'b0);
      u_host.xfer(UESC_EP1, 1'b0);
      rd(UESC_OFF_EP1, 8'h0e);
      bchk("rx1_tog", rx1t, 1'b1);
      rd(UESC_OFF_BSR, 8'hc8);
      u_host.xfer(UESC_EP2, 1'b1);
      rd(UESC_OFF_BSR, 8'hf0);
      // each error code, the reserved one folded onto other
      for (int c = 1; c < 8; c++) begin
         u_host.error(3'(c));
         rd(UESC_OFF_BSR, 8'hf0 | ((c == 6) ? 8'h07 : 8'(c)));
         u_host.error_clear();
         rd(UESC_OFF_BSR, 8'hf0);
      end
      // forced and bus resets clear toggles and status, keep done
      u_host.xfer(UESC_EP0, 1'b0);
      wr(UESC_OFF_CTRL, 8'h01);
      @(posedge mclk_i);
      bchk("iface_reset", ifr, 1'b1);
      rd(UESC_OFF_CTRL, 8'h01);
      rd(UESC_OFF_EP0, 8'h80);
      rd(UESC_OFF_EP1, 8'h08);
      wr(UESC_OFF_CTRL, 8'h00);
      wr(UESC_OFF_EP0, 8'hf3);
      rd(UESC_OFF_EP0, 8'hf3);
      wr(UESC_OFF_EP1, 8'h0f);
      u_host.bus_reset(3);
      rd(UESC_OFF_EP0, 8'h80);
      rd(UESC_OFF_EP1, 8'h08);
      // random toggle and status patterns written by software
      for (int i = 0; i < 6; i++) begin
         v = 8'($urandom);
         wr(UESC_OFF_EP0, v & 8'h7f);
         rd(UESC_OFF_EP0, v & 8'h77);
         wr(UESC_OFF_EP1, v & 8'hf7);
         rd(UESC_OFF_EP1, v & 8'h07);
      end
      repeat (2) @(posedge mclk_i);
      bchk("queue_empty", exp_q.size() == 0, 1'b1);
      report_and_stop();
   end
endmodule // tb
